// >>> tbp_defs.svh
// Constants for the timer with buzzer and PWM output.
// Operation
// - Buzzer toggles once per overflow, half rate.
// - Buzzer enable takes the shared pin.
// - Buzzer works only while PWM disabled.
// - Timer disable halts count, buzzer, PWM.
// - Prescaler select sits in mode bits six-four.
// - External source ignores the prescaler select.
// - Source bit: zero internal, one external.
// - PWM modulus 256, 64, 32, 16 by bits.
// - PWM goes low when count equals reload.
// - PWM set high when counter wraps zero, unless reload is zero.
// - PWM duty equals reload over modulus.
// - PWM enable takes the shared pin.
// - Request flag raised once per PWM period.
// - Reload register reads back as zero.
// - Auto-reload loads reload value at overflow.
// - Reload writes held until next overflow while enabled.
// - PWM mode always reloads; bit selects modulus.
// - External source is the event pin.
`ifndef TBP_DEFS_SVH
`define TBP_DEFS_SVH
`define TBP_IDX_MODE 8'hDC
`define TBP_IDX_COUNT 8'hDD
`define TBP_IDX_RELOAD 8'hDE
`define TBP_IDX_STATUS 8'hDF
`define TBP_ADDR_W 10
`define TBP_BIT_PWM 0
`define TBP_BIT_BUZ 1
`define TBP_BIT_ALOAD 2
`define TBP_BIT_CKS 3
`define TBP_BIT_RATE_LO 4
`define TBP_BIT_RATE_HI 6
`define TBP_BIT_ENB 7
`define TBP_BIT_FLAG 0
`define TBP_BIT_IEN 1
`define TBP_RST_BYTE 8'h00
`define TBP_MASK_256 8'hFF
`define TBP_MASK_64 8'h3F
`define TBP_MASK_32 8'h1F
`define TBP_MASK_16 8'h0F
`define TBP_ONE_BYTE 8'h01
`define TBP_RD_PAD 24'h000000
`define TBP_STAT_PAD 6'h00
`endif

// >>> tbp_load_model.sv
// Load on the shared pin that measures the period and high time of its waveform.
`timescale 1ns/100ps
module tbp_load_model (
  input wire logic mclk_in,
  input wire logic pin_in,
  input wire logic oe_in,
  output int period_out,
  output int high_out,
  output int edges_out
);
  // A released pin is pulled down by the load, so it never shows a stale level.
  wire logic line = oe_in ? pin_in : 1'b0;
  logic last_ff = 1'b0;
  int cnt = 0;
  int hi = 0;
  int per = 0;
  int hig = 0;
  int edg = 0;
  assign period_out = per;
  assign high_out = hig;
  assign edges_out = edg;
  always @(posedge mclk_in)
  begin
    last_ff <= line;
    if (line && !last_ff)
    begin
      per <= cnt;
      hig <= hi;
      edg <= edg + 1;
      cnt <= 1;
      hi <= 1;
    end
    else
    begin
      cnt <= cnt + 1;
      hi <= hi + (line ? 1 : 0);
    end
  end
endmodule : tbp_load_model

// >>> tbp_pkg.sv
// Types shared by the timer modules.
package tbp_pkg;
  typedef logic [7:0] tbp_byte_t;
  typedef enum logic [1:0] {
    TBP_RANGE_256 = 2'b00,
    TBP_RANGE_64 = 2'b01,
    TBP_RANGE_32 = 2'b10,
    TBP_RANGE_16 = 2'b11
  } tbp_range_t;
endpackage : tbp_pkg

// >>> tbp_tick_gen.sv
// Count tick source: internal prescaler or external event pin.
`timescale 1ns/100ps
`include "tbp_defs.svh"
module tbp_tick_gen (
  input wire logic mclk_in,
  input wire logic resetn_in,
  input wire logic external_event_pin_in,
  tbp_tick_if.gen tick_if
);
  logic [7:0] pre_ff;
  logic [2:0] sync_ff;
  logic lvl_ff;
  wire [7:0] rate_mask = `TBP_MASK_256 >> tick_if.prescaler_select;
  wire int_tick = (pre_ff & rate_mask) == rate_mask;
  wire agree = sync_ff[1] == sync_ff[2];
  wire ext_fall = lvl_ff & agree & ~sync_ff[2];

  // Code 000 divides by 256 and 111 by 2.
  always_ff @(posedge mclk_in)
  begin
    if (!resetn_in)
      pre_ff <= `TBP_RST_BYTE;
    else
      pre_ff <= pre_ff + `TBP_ONE_BYTE;
  end

  // A level counts once two later stages agree, filtering one-cycle spikes.
  always_ff @(posedge mclk_in)
  begin
    if (!resetn_in)
    begin
      sync_ff <= 3'h7;
      lvl_ff <= 1'b1;
    end
    else
    begin
      sync_ff <= {sync_ff[1:0], external_event_pin_in};
      if (agree)
        lvl_ff <= sync_ff[2];
    end
  end

  assign tick_if.tick = tick_if.clock_source_select ? ext_fall : int_tick;

  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!resetn_in);

  a_int_tick_rate: assert property (!tick_if.clock_source_select && tick_if.tick |->
    (pre_ff & (8'hFF >> tick_if.prescaler_select)) == (8'hFF >> tick_if.prescaler_select))
    else $error("internal tick off the prescaler boundary");
  a_ext_tick_edge: assert property (tick_if.clock_source_select && tick_if.tick |=> !lvl_ff)
    else $error("external tick without a falling edge");
endmodule : tbp_tick_gen

// >>> tbp_tick_if.sv
// Carrier between the tick generator and the timer core.
`timescale 1ns/100ps
interface tbp_tick_if;
  logic clock_source_select;
  logic [2:0] prescaler_select;
  logic tick;
  modport gen (input clock_source_select, input prescaler_select, output tick);
  modport timer (output clock_source_select, output prescaler_select, input tick);
endinterface : tbp_tick_if

// >>> tbp_timer_top.sv
// Timer core with buzzer and PWM output and its Avalon-MM register slave.
//
// Implementation choices: the Avalon-MM slave port and the register addresses.
`timescale 1ns/100ps
`include "tbp_defs.svh"
module tbp_timer_top (
  input wire logic mclk_in,
  input wire logic resetn_in,
  input wire logic [9:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  input wire logic external_event_pin_in,
  input wire logic gpio_out_in,
  input wire logic gpio_oe_in,
  output logic shared_output_pin_out,
  output logic shared_output_pin_oe_out,
  output logic timer_request_flag_out,
  output logic timer_irq_out
);
  tbp_tick_if tick_if ();

  logic ack_ff;
  logic [31:0] readdata_ff;
  tbp_pkg::tbp_byte_t mode_ff;
  tbp_pkg::tbp_byte_t count_ff;
  tbp_pkg::tbp_byte_t rld_buf_ff;
  tbp_pkg::tbp_byte_t rld_act_ff;
  logic flag_ff;
  logic ien_ff;
  logic buzz_ff;
  logic pwm_ff;
  logic pin_ff;
  logic pin_oe_ff;
  logic irq_ff;

  tbp_tick_gen i_tbp_tick_gen (
    .mclk_in(mclk_in),
    .resetn_in(resetn_in),
    .external_event_pin_in(external_event_pin_in),
    .tick_if(tick_if)
  );

  // Bus slave: every access waits exactly one cycle, then completes.
  wire bus_req = avs_read_in | avs_write_in;
  wire bus_wr = avs_write_in & ack_ff & avs_byteenable_in[0];
  wire bus_rd_take = avs_read_in & ~ack_ff;
  wire [7:0] wbyte = avs_writedata_in[7:0];
  wire sel_mode = avs_address_in == {`TBP_IDX_MODE, 2'b00};
  wire sel_count = avs_address_in == {`TBP_IDX_COUNT, 2'b00};
  wire sel_reload = avs_address_in == {`TBP_IDX_RELOAD, 2'b00};
  wire sel_status = avs_address_in == {`TBP_IDX_STATUS, 2'b00};
  wire mode_we = bus_wr & sel_mode;
  wire cnt_we = bus_wr & sel_count;
  wire rld_we = bus_wr & sel_reload;
  wire stat_we = bus_wr & sel_status;
  wire [7:0] stat_byte = {`TBP_STAT_PAD, ien_ff, flag_ff};
  // The reload register is write-only, so its offset reads as zero.
  wire [7:0] rd_mux = sel_mode ? mode_ff :
                      sel_count ? count_ff :
                      sel_status ? stat_byte : `TBP_RST_BYTE;

  assign avs_waitrequest_out = bus_req & ~ack_ff;
  assign avs_readdata_out = readdata_ff;

  always_ff @(posedge mclk_in)
  begin
    if (!resetn_in)
      ack_ff <= 1'b0;
    else
      ack_ff <= bus_req & ~ack_ff;
  end

  always_ff @(posedge mclk_in)
  begin
    if (!resetn_in)
      readdata_ff <= 32'h00000000;
    else if (bus_rd_take)
      readdata_ff <= {`TBP_RD_PAD, rd_mux};
  end

  // Mode fields.
  wire pwm_en = mode_ff[`TBP_BIT_PWM];
  wire buz_en = mode_ff[`TBP_BIT_BUZ];
  wire aload = mode_ff[`TBP_BIT_ALOAD];
  wire enb = mode_ff[`TBP_BIT_ENB];
  assign tick_if.clock_source_select = mode_ff[`TBP_BIT_CKS];
  assign tick_if.prescaler_select = mode_ff[`TBP_BIT_RATE_HI:`TBP_BIT_RATE_LO];

  // In PWM mode the reload and buzzer bits choose the modulus.
  wire tbp_pkg::tbp_range_t range = tbp_pkg::tbp_range_t'({aload, buz_en});
  wire [7:0] mod_mask = !pwm_en ? `TBP_MASK_256 :
                        range == tbp_pkg::TBP_RANGE_64 ? `TBP_MASK_64 :
                        range == tbp_pkg::TBP_RANGE_32 ? `TBP_MASK_32 :
                        range == tbp_pkg::TBP_RANGE_16 ? `TBP_MASK_16 : `TBP_MASK_256;

  // Counter datapath.
  wire step = enb & tick_if.tick;
  wire [7:0] cnt_m = count_ff & mod_mask;
  wire ovf = step & (cnt_m == mod_mask);
  wire [7:0] cnt_inc = count_ff + `TBP_ONE_BYTE;
  wire [7:0] cnt_inc_m = cnt_inc & mod_mask;
  wire [7:0] rld_buf_m = rld_buf_ff & mod_mask;
  wire [7:0] rld_act_m = rld_act_ff & mod_mask;
  // PWM wraps to zero and reloads only its compare value; plain auto-reload
  // loads the counter; otherwise the counter just rolls over.
  wire [7:0] ovf_count = pwm_en ? `TBP_RST_BYTE :
                         aload ? rld_buf_ff : cnt_inc;
  wire [7:0] nxt_count = cnt_we ? wbyte :
                         ovf ? ovf_count :
                         step ? cnt_inc : count_ff;
  // While stopped the buffer passes straight through, so the first period
  // after enabling already uses the value written during setup.
  wire [7:0] nxt_rld_act = (ovf | ~enb) ? rld_buf_ff : rld_act_ff;
  wire [7:0] nxt_rld_buf = rld_we ? wbyte : rld_buf_ff;
  // A hardware overflow in the same cycle as a software clear wins.
  wire nxt_flag = ovf | (stat_we ? wbyte[`TBP_BIT_FLAG] : flag_ff);
  wire nxt_ien = stat_we ? wbyte[`TBP_BIT_IEN] : ien_ff;
  wire nxt_buzz = (~enb | pwm_en) ? 1'b0 :
                  ovf ? ~buzz_ff : buzz_ff;
  // High for the reload count of ticks out of each period.
  wire pwm_eq = step & ~ovf & (cnt_inc_m == rld_act_m);
  wire nxt_pwm = (~enb | ~pwm_en) ? 1'b0 :
                 ovf ? (rld_buf_m != `TBP_RST_BYTE) :
                 pwm_eq ? 1'b0 : pwm_ff;
  wire owns_pin = pwm_en | buz_en;
  wire pin_level = pwm_en ? pwm_ff : buzz_ff;
  wire nxt_pin = owns_pin ? pin_level : gpio_out_in;
  wire nxt_pin_oe = owns_pin | gpio_oe_in;

  always_ff @(posedge mclk_in)
  begin
    if (!resetn_in)
    begin
      mode_ff <= `TBP_RST_BYTE;
      count_ff <= `TBP_RST_BYTE;
      rld_buf_ff <= `TBP_RST_BYTE;
      rld_act_ff <= `TBP_RST_BYTE;
    end
    else
    begin
      if (mode_we)
        mode_ff <= wbyte;
      count_ff <= nxt_count;
      rld_buf_ff <= nxt_rld_buf;
      rld_act_ff <= nxt_rld_act;
    end
  end

  always_ff @(posedge mclk_in)
  begin
    if (!resetn_in)
    begin
      flag_ff <= 1'b0;
      ien_ff <= 1'b0;
      buzz_ff <= 1'b0;
      pwm_ff <= 1'b0;
    end
    else
    begin
      flag_ff <= nxt_flag;
      ien_ff <= nxt_ien;
      buzz_ff <= nxt_buzz;
      pwm_ff <= nxt_pwm;
    end
  end

  // Pin outputs are registered so the pad never sees mux glitches.
  always_ff @(posedge mclk_in)
  begin
    if (!resetn_in)
    begin
      pin_ff <= 1'b0;
      pin_oe_ff <= 1'b0;
      irq_ff <= 1'b0;
    end
    else
    begin
      pin_ff <= nxt_pin;
      pin_oe_ff <= nxt_pin_oe;
      irq_ff <= flag_ff & ien_ff;
    end
  end

  assign shared_output_pin_out = pin_ff;
  assign shared_output_pin_oe_out = pin_oe_ff;
  assign timer_request_flag_out = flag_ff;
  assign timer_irq_out = irq_ff;

  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!resetn_in);

  sequence s_bus_wait;
    bus_req && avs_waitrequest_out;
  endsequence
  sequence s_bus_done;
    !avs_waitrequest_out;
  endsequence
  sequence s_buzz_ovf;
    ovf && buz_en && !pwm_en;
  endsequence
  sequence s_pwm_wrap;
    ovf && pwm_en && rld_buf_m != 8'h00 && !cnt_we && !mode_we;
  endsequence
  sequence s_pwm_high;
    pwm_ff ##1 shared_output_pin_out;
  endsequence
  sequence s_cnt_step;
    step && !ovf && !cnt_we;
  endsequence

  a_bus_one_wait: assert property (s_bus_wait and avs_read_in |=> s_bus_done)
    else $error("bus access held longer than one wait cycle");
  a_buzz_toggle_ovf: assert property (s_buzz_ovf |=> buzz_ff != $past(buzz_ff))
    else $error("buzzer did not toggle on overflow");
  a_buzz_hold_between: assert property (enb && !pwm_en && !ovf |=> buzz_ff == $past(buzz_ff))
    else $error("buzzer changed without overflow");
  a_pin_owned: assert property (owns_pin |=> shared_output_pin_oe_out
    && shared_output_pin_out == $past(pin_level))
    else $error("shared pin not driven by the timer");
  a_pwm_blocks_buzz: assert property (pwm_en |=> !buzz_ff)
    else $error("buzzer active while PWM enabled");
  a_stop_disabled: assert property (!enb && !cnt_we |=> !buzz_ff && !pwm_ff
    && count_ff == $past(count_ff))
    else $error("timer activity while disabled");
  a_pwm_low_equal: assert property (pwm_en && enb && pwm_eq |=> !pwm_ff)
    else $error("PWM not low at compare match");
  a_pwm_high_wrap: assert property (pwm_en && enb && ovf && rld_buf_m != 8'h00 && !cnt_we
    |=> pwm_ff && count_ff == 8'h00)
    else $error("PWM not high after wrap");
  a_pwm_mod_16: assert property (pwm_en && aload && buz_en && step
    && (count_ff & 8'h0F) == 8'h0F |-> ovf)
    else $error("modulus 16 overflow missed");
  a_flag_on_ovf: assert property (ovf |=> flag_ff ##1 timer_irq_out == $past(ien_ff))
    else $error("request flag not set on overflow");
  a_reload_read_zero: assert property (avs_read_in && bus_rd_take && sel_reload
    |=> avs_readdata_out == 32'h00000000)
    else $error("reload register read back nonzero");
  a_reload_transfer: assert property (ovf |=> rld_act_ff == $past(rld_buf_ff))
    else $error("reload buffer not transferred at overflow");
  a_reload_held: assert property (enb && !ovf |=> rld_act_ff == $past(rld_act_ff))
    else $error("active reload changed before overflow");
  a_aload_count: assert property (ovf && aload && !pwm_en && !cnt_we
    |=> count_ff == $past(rld_buf_ff))
    else $error("auto-reload did not load the counter");
  a_plain_wrap: assert property (ovf && !aload && !pwm_en && !cnt_we |=> count_ff == 8'h00)
    else $error("counter did not wrap through zero");

  // The pin checks add one cycle for the output register in front of the pad.
  a_bus_write_wait: assert property (s_bus_wait and avs_write_in |=> s_bus_done)
    else $error("write held longer than one wait cycle");
  a_ack_idle: assert property (!bus_req |=> !ack_ff)
    else $error("bus acknowledge without a request");
  a_read_mode: assert property (bus_rd_take && sel_mode
    |=> avs_readdata_out == {24'h000000, $past(mode_ff)})
    else $error("mode register read back wrong");
  a_count_step: assert property (s_cnt_step |=> count_ff == $past(count_ff) + 8'h01)
    else $error("counter did not advance on a tick");
  a_count_hold: assert property (!step && !cnt_we |=> count_ff == $past(count_ff))
    else $error("counter moved without a tick");
  a_stop_no_ovf: assert property (!enb |-> !ovf)
    else $error("overflow while the timer is disabled");
  a_pwm_mod_64: assert property (pwm_en && !aload && buz_en && step
    && (count_ff & 8'h3F) == 8'h3F |-> ovf)
    else $error("modulus 64 overflow missed");
  a_pwm_mod_32: assert property (pwm_en && aload && !buz_en && step
    && (count_ff & 8'h1F) == 8'h1F |-> ovf)
    else $error("modulus 32 overflow missed");
  a_full_mod_256: assert property (!(pwm_en && (aload || buz_en)) && step
    && count_ff == 8'hFF |-> ovf)
    else $error("modulus 256 overflow missed");
  a_mod_16_early: assert property (pwm_en && aload && buz_en
    && (count_ff & 8'h0F) != 8'h0F |-> !ovf)
    else $error("modulus 16 overflow too early");
  a_pwm_wrap_zero: assert property (ovf && pwm_en && !cnt_we
    |=> count_ff == 8'h00)
    else $error("PWM counter did not restart at zero");
  a_pwm_pin_high: assert property (s_pwm_wrap |=> s_pwm_high)
    else $error("pin not high after PWM wrap");
  a_pwm_zero_duty: assert property (ovf && pwm_en && rld_buf_m == 8'h00 |=> !pwm_ff)
    else $error("zero duty PWM went high");
  a_pwm_hold_level: assert property (pwm_en && enb && !ovf && !pwm_eq
    |=> pwm_ff == $past(pwm_ff))
    else $error("PWM level changed between events");
  a_flag_set_wins: assert property (ovf && stat_we |=> flag_ff)
    else $error("flag clear beat a same-cycle overflow");
  a_flag_sticky: assert property (flag_ff && !stat_we |=> flag_ff)
    else $error("request flag dropped without a write");
  a_flag_no_spur: assert property (!flag_ff && !ovf && !stat_we |=> !flag_ff)
    else $error("request flag set without overflow");
  a_ien_write: assert property (stat_we |=> ien_ff == $past(wbyte[`TBP_BIT_IEN]))
    else $error("interrupt enable not written");
  a_irq_follows: assert property (resetn_in
    |=> timer_irq_out == $past(flag_ff && ien_ff))
    else $error("interrupt output does not follow flag and enable");
  a_gpio_pass: assert property (!owns_pin
    |=> shared_output_pin_out == $past(gpio_out_in)
    && shared_output_pin_oe_out == $past(gpio_oe_in))
    else $error("pin not returned to general purpose use");
  a_reload_buf_write: assert property (rld_we |=> rld_buf_ff == $past(wbyte))
    else $error("reload write not held in the buffer");
  a_reload_stopped: assert property (!enb |=> rld_act_ff == $past(rld_buf_ff))
    else $error("stopped timer did not pass the reload buffer");
endmodule : tbp_timer_top

// >>> timer_buzzer_pwm_output_test.sv
// Self-checking bench for the timer with buzzer and PWM output.
`timescale 1ns/100ps
`include "tbp_defs.svh"
module timer_buzzer_pwm_output_test;
  logic mclk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic [9:0] address = 10'h000;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] wdata = 32'h00000000;
  logic [31:0] rdata;
  logic waitreq;
  logic event_pin = 1'b1;
  logic gpio_out = 1'b0;
  logic gpio_oe = 1'b0;
  logic pin;
  logic pin_oe;
  logic flag;
  logic irq;
  logic [7:0] a;
  logic [7:0] b;
  int period;
  int high;
  int edges;
  int bad_count = 0;
  int n_checks = 0;
  int mods[4] = '{256, 64, 32, 16};
  always #10 mclk_in = ~mclk_in;
  tbp_timer_top i_tbp_timer_top (.mclk_in(mclk_in), .resetn_in(resetn_in),
    .avs_address_in(address), .avs_read_in(read), .avs_write_in(write),
    .avs_writedata_in(wdata), .avs_byteenable_in(4'hF), .avs_readdata_out(rdata),
    .avs_waitrequest_out(waitreq), .external_event_pin_in(event_pin),
    .gpio_out_in(gpio_out), .gpio_oe_in(gpio_oe), .shared_output_pin_out(pin),
    .shared_output_pin_oe_out(pin_oe), .timer_request_flag_out(flag), .timer_irq_out(irq));
  tbp_load_model i_tbp_load_model (.mclk_in(mclk_in), .pin_in(pin), .oe_in(pin_oe),
    .period_out(period), .high_out(high), .edges_out(edges));
  task conclude;
    $display("Comparisons %0d, mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : conclude
  task check(input logic [15:0] got, input logic [15:0] exp, input string what);
    n_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check
  // The request stands until waitrequest is sampled low at a rising edge.
  task bus(input logic wr, input logic [7:0] idx, input logic [7:0] d, output logic [7:0] q);
    @(posedge mclk_in);
    address <= {idx, 2'b00};
    wdata <= {24'h000000, d};
    read <= !wr;
    write <= wr;
    do
      @(posedge mclk_in);
    while (waitreq !== 1'b0);
    q = rdata[7:0];
    read <= 1'b0;
    write <= 1'b0;
  endtask : bus
  task wr(input logic [7:0] idx, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, idx, d, q);
  endtask : wr
  task wait_edges(input int n);
    int g;
    g = 0;
    while (edges < n && g < 5000)
    begin
      @(posedge mclk_in);
      g++;
    end
    if (edges < n)
    begin
      bad_count++;
      $display("CHECK FAILED at %0t: waveform edges missing", $time);
    end
  endtask : wait_edges
  task t_reset;
    bus(1'b0, `TBP_IDX_MODE, 8'h00, a);
    check(a, 8'h00, "mode reset");
    bus(1'b0, `TBP_IDX_STATUS, 8'h00, a);
    check(a, 8'h00, "status reset");
    bus(1'b0, 8'h00, 8'h00, a);
    check(a, 8'h00, "unmapped read");
    wr(`TBP_IDX_RELOAD, 8'h5A);
    bus(1'b0, `TBP_IDX_RELOAD, 8'h00, a);
    check(a, 8'h00, "reload readback");
    gpio_oe <= 1'b1;
    gpio_out <= 1'b1;
    repeat (3) @(posedge mclk_in);
    check({pin_oe, pin}, 16'h0003, "gpio owns pin");
  endtask : t_reset
  task t_pwm;
    int base;
    for (int r = 0; r < 4; r++)
    begin
      wr(`TBP_IDX_MODE, 8'h00);
      wr(`TBP_IDX_STATUS, 8'h00);
      wr(`TBP_IDX_COUNT, 8'h00);
      wr(`TBP_IDX_RELOAD, 8'h03);
      wr(`TBP_IDX_MODE, {5'b11110, 2'(r), 1'b1});
      base = edges;
      wait_edges(base + 3);
      check(16'(period), 16'(2 * mods[r]), "pwm period");
      check(16'(high), 16'h0006, "pwm high");
      check({pin_oe, flag}, 16'h0003, "pin owned, flag");
    end
    wr(`TBP_IDX_RELOAD, 8'h05);
    base = edges;
    wait_edges(base + 2);
    check(16'(high), 16'h000A, "new duty");
    wr(`TBP_IDX_MODE, 8'h77);
    bus(1'b0, `TBP_IDX_COUNT, 8'h00, a);
    repeat (20) @(posedge mclk_in);
    bus(1'b0, `TBP_IDX_COUNT, 8'h00, b);
    check(b, a, "count halted");
    check(pin, 1'b0, "pwm stopped");
  endtask : t_pwm
  task t_buzzer;
    int base;
    wr(`TBP_IDX_MODE, 8'h00);
    wr(`TBP_IDX_COUNT, 8'hF0);
    wr(`TBP_IDX_RELOAD, 8'hF0);
    wr(`TBP_IDX_MODE, 8'hE6);
    base = edges;
    wait_edges(base + 3);
    check(16'(period), 16'h0080, "buzzer period");
    check(16'(high), 16'h0040, "buzzer high");
    check(pin_oe, 1'b1, "buzzer owns pin");
  endtask : t_buzzer
  task t_wrap;
    wr(`TBP_IDX_MODE, 8'h00);
    wr(`TBP_IDX_STATUS, 8'h02);
    wr(`TBP_IDX_COUNT, 8'hFE);
    wr(`TBP_IDX_MODE, 8'hF0);
    repeat (12) @(posedge mclk_in);
    wr(`TBP_IDX_MODE, 8'h70);
    bus(1'b0, `TBP_IDX_STATUS, 8'h00, a);
    check(a, 8'h03, "overflow flag");
    check(irq, 1'b1, "interrupt output");
    bus(1'b0, `TBP_IDX_COUNT, 8'h00, a);
    check(a < 8'h10, 1'b1, "count wrapped");
  endtask : t_wrap
  task t_event;
    wr(`TBP_IDX_MODE, 8'h00);
    wr(`TBP_IDX_COUNT, 8'h00);
    wr(`TBP_IDX_MODE, 8'hF8);
    repeat (5)
    begin
      @(posedge mclk_in);
      event_pin <= 1'b0;
      repeat (8) @(posedge mclk_in);
      event_pin <= 1'b1;
      repeat (8) @(posedge mclk_in);
    end
    wr(`TBP_IDX_MODE, 8'h78);
    bus(1'b0, `TBP_IDX_COUNT, 8'h00, a);
    check(a, 8'h05, "event count");
  endtask : t_event
  initial
  begin
    repeat (16) @(posedge mclk_in);
    resetn_in <= 1'b1;
    t_reset();
    t_pwm();
    t_buzzer();
    t_wrap();
    t_event();
    conclude();
  end
  initial
  begin
    repeat (40000) @(posedge mclk_in);
    bad_count++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    conclude();
  end
endmodule : timer_buzzer_pwm_output_test
